/* File: inc/preset_cmp_pkg.sv */
package preset_cmp_pkg;

  localparam int VAL_W  = 24;
  localparam int TIME_W = 24;

  typedef enum logic [2:0] {
    MODE_ABS_GE    = 3'h0,
    MODE_ABS_LE    = 3'h1,
    MODE_ABS_WIN   = 3'h2,
    MODE_STANDSTIL = 3'h3,
    MODE_SGN_GE    = 3'h4,
    MODE_SGN_LE    = 3'h5,
    MODE_SGN_WIN   = 3'h6,
    MODE_FORWARD   = 3'h7
  } sw_mode_t;

  typedef struct packed {
    sw_mode_t                  mode;
    logic                      latch_en;
    logic signed [VAL_W-1:0]   preset;
    logic        [VAL_W-1:0]   hyst;
    logic        [TIME_W-1:0]  stand_ticks;
    logic        [TIME_W-1:0]  start_ticks;
  } sw_cfg_t;

  typedef struct packed {
    logic signed [VAL_W-1:0] speed;
    logic                    zero_freq;
    logic                    forward;
  } speed_in_t;

  localparam logic [TIME_W-1:0] TIME_ZERO = 24'h000000;
  localparam logic [TIME_W-1:0] TIME_ONE  = 24'h000001;

endpackage

/* File: design/tick_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// Counts enabled ticks while run is high; done once limit ticks seen.
module tick_timer
  import preset_cmp_pkg::*;
(
  input  wire logic              clk_in,    // System clock
  input  wire logic              rst_n_in,  // Sync reset, active low
  input  wire logic              run_in,    // Count while high, else clear
  input  wire logic              tick_in,   // Time base enable
  input  wire logic [TIME_W-1:0] limit_in,  // Ticks to wait
  output logic                   done_out   // Limit reached
);
  logic [TIME_W-1:0] cnt_r;
  logic [TIME_W-1:0] cnt_nxt;
  logic              reached;

  assign reached  = (cnt_r >= limit_in);
  assign cnt_nxt  = !run_in ? TIME_ZERO :
                    (tick_in && !reached) ? cnt_r + TIME_ONE : cnt_r;
  assign done_out = run_in && reached;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) cnt_r <= TIME_ZERO;
    else cnt_r <= cnt_nxt;
  end
endmodule
`default_nettype wire

/* File: design/speed_preset_switch_compare.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// - Mode 0: on when magnitude at or above preset; no start delay; latch ok.
// - Mode 1: on when magnitude at or below preset; start delay; latch ok.
// - Mode 2: on at magnitude at or below preset minus hysteresis; delay; latch.
// - Mode 2: off at magnitude at or above preset plus hysteresis.
// - Mode 3: on after zero frequency plus standstill time; no delay/latch.
// - Mode 4: on when signed value at or above preset; latch ok.
// - Mode 5: on when signed value at or below preset; latch ok.
// - Mode 6: signed window with hysteresis; no start delay; latch ok.
// - Mode 7: output follows forward rotation.
// - Each output has its own hysteresis used in its window compare.
// - Modes 0 to 2 compare magnitude, ignoring sign.
// - Signed modes respect the sign of the speed.
module speed_preset_switch_compare
  import preset_cmp_pkg::*;
(
  input  wire logic                 core_clk_in,  // 125 MHz system clock
  input  wire logic                 rst_n_in,     // Sync reset, active low
  input  wire preset_cmp_pkg::sw_cfg_t   cfg_in,  // Mode, preset, times
  input  wire preset_cmp_pkg::speed_in_t spd_in,  // From measuring core
  input  wire logic                 tick_in,      // Time base enable pulse
  input  wire logic                 meas_start_in,// Pulse: measurement starts
  input  wire logic                 latch_clr_in, // Pulse: clear latch
  output logic                      switch_out,   // Switching output
  output logic                      delay_busy_out// Start delay running
);
  import preset_cmp_pkg::*;

  logic                    sw_r;
  logic                    sw_nxt;
  logic                    latched_r;
  logic                    latched_nxt;
  logic                    win_r;
  logic                    win_nxt;
  logic                    dly_run_r;
  logic                    dly_done;
  logic                    stand_done;
  logic signed [VAL_W:0]   act;
  logic signed [VAL_W:0]   pre;
  logic signed [VAL_W:0]   hys;
  logic                    signed_mode;
  logic                    use_delay;
  logic                    can_latch;
  logic                    cond;
  logic                    raw_on;
  logic                    dly_gate;

  // Extra bit keeps magnitude of the most negative speed exact
  assign signed_mode = cfg_in.mode[2];
  assign act = (!signed_mode && spd_in.speed < 0) ?
               -{spd_in.speed[VAL_W-1], spd_in.speed} :
               {spd_in.speed[VAL_W-1], spd_in.speed};
  assign pre = {cfg_in.preset[VAL_W-1], cfg_in.preset};
  assign hys = {1'b0, cfg_in.hyst};

  // Window: on at or below preset-hyst, off at or above preset+hyst, hold between
  assign win_nxt = (act <= pre - hys) ? 1'b1 :
                   (act >= pre + hys) ? 1'b0 : win_r;

  assign use_delay = (cfg_in.mode == MODE_ABS_LE) ||
                     (cfg_in.mode == MODE_ABS_WIN);
  assign can_latch = (cfg_in.mode != MODE_STANDSTIL) &&
                     (cfg_in.mode != MODE_FORWARD);

  always_comb begin
    case (cfg_in.mode)
      MODE_ABS_GE:    cond = (act >= pre);
      MODE_ABS_LE:    cond = (act <= pre);
      MODE_ABS_WIN:   cond = win_nxt;
      MODE_STANDSTIL: cond = stand_done;
      MODE_SGN_GE:    cond = (act >= pre);
      MODE_SGN_LE:    cond = (act <= pre);
      MODE_SGN_WIN:   cond = win_nxt;
      MODE_FORWARD:   cond = spd_in.forward;
      default:        cond = 1'b0;
    endcase
  end

  // Slow speed at start would trip low-threshold modes; hold them off,
  // from the start pulse itself until the delay timer reports done
  assign dly_gate = use_delay &&
                    ((meas_start_in && !dly_run_r) ||
                     (dly_run_r && !dly_done));
  assign raw_on   = cond && !dly_gate;
  assign latched_nxt = latch_clr_in ? 1'b0 :
                       (latched_r || (cfg_in.latch_en && can_latch && raw_on));
  assign sw_nxt = raw_on || (latched_nxt && can_latch);

  tick_timer u_start_dly (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n_in),
    .run_in   (dly_run_r),
    .tick_in  (tick_in),
    .limit_in (cfg_in.start_ticks),
    .done_out (dly_done)
  );

  tick_timer u_standstill (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n_in),
    .run_in   (spd_in.zero_freq),
    .tick_in  (tick_in),
    .limit_in (cfg_in.stand_ticks),
    .done_out (stand_done)
  );

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sw_r      <= 1'b0;
      latched_r <= 1'b0;
      win_r     <= 1'b0;
      dly_run_r <= 1'b0;
    end else begin
      sw_r      <= sw_nxt;
      latched_r <= latched_nxt;
      win_r     <= win_nxt;
      if (meas_start_in) dly_run_r <= 1'b1;
      else if (dly_done) dly_run_r <= 1'b0;
    end
  end

  assign switch_out     = sw_r;
  assign delay_busy_out = dly_run_r;

  // Each check looks one edge after its inputs, at the registered output
  ge_mode_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_ABS_GE && act >= pre) |=> switch_out)
    else $error("ge mode did not switch");

  abs_sign_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_ABS_GE && cfg_in.preset > 0 &&
     spd_in.speed <= -cfg_in.preset) |=> switch_out)
    else $error("magnitude compare used the sign");

  le_mode_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_ABS_LE && act <= pre && !dly_run_r &&
     !meas_start_in) |=> switch_out)
    else $error("le mode did not switch");

  win_on_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_ABS_WIN && act <= pre - hys && !dly_run_r &&
     !meas_start_in) |=> switch_out)
    else $error("window did not switch on");

  win_off_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    ((cfg_in.mode == MODE_ABS_WIN || cfg_in.mode == MODE_SGN_WIN) &&
     act >= pre + hys && hys > 0 && !latched_nxt) |=> !switch_out)
    else $error("window did not switch off");

  sgn_win_on_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_SGN_WIN && act <= pre - hys) |=> switch_out)
    else $error("signed window did not switch on");

  stand_gate_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_STANDSTIL && !spd_in.zero_freq) |=> !switch_out)
    else $error("standstill on while moving");

  stand_on_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_STANDSTIL && stand_done) |=> switch_out)
    else $error("standstill did not switch on");

  sgn_ge_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_SGN_GE && spd_in.speed >= cfg_in.preset)
      |=> switch_out)
    else $error("signed ge did not switch");

  sgn_dir_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_SGN_GE && cfg_in.preset > 0 &&
     spd_in.speed < 0 && !latched_nxt) |=> !switch_out)
    else $error("signed mode switched on reverse speed");

  sgn_le_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_SGN_LE && spd_in.speed <= cfg_in.preset)
      |=> switch_out)
    else $error("signed le did not switch");

  fwd_follow_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg_in.mode == MODE_FORWARD) |=> (switch_out == $past(spd_in.forward)))
    else $error("forward mode mismatch");

  dly_hold_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (use_delay && dly_run_r && !dly_done && !latched_r && !latched_nxt)
      |=> !switch_out)
    else $error("output on during start delay");

  start_gate_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (use_delay && meas_start_in && !dly_run_r && !latched_nxt)
      |=> !switch_out)
    else $error("output on in start cycle");

  dly_end_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (dly_run_r && dly_done && !meas_start_in) |=> !delay_busy_out)
    else $error("start delay did not end");

  latch_hold_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (latched_r && can_latch && !latch_clr_in) |=> switch_out)
    else $error("latched output dropped");

  latch_clr_a: assert property (
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (latch_clr_in && !raw_on) |=> !switch_out)
    else $error("latch clear did not drop output");

  // Main scenarios the bench is expected to reach
  ge_cov_c:    cover property (@(posedge core_clk_in)
    cfg_in.mode == MODE_ABS_GE && switch_out);
  dly_cov_c:   cover property (@(posedge core_clk_in)
    $fell(delay_busy_out));
  win_cov_c:   cover property (@(posedge core_clk_in)
    cfg_in.mode == MODE_ABS_WIN && $fell(switch_out));
  stand_cov_c: cover property (@(posedge core_clk_in)
    cfg_in.mode == MODE_STANDSTIL && $rose(switch_out));
  latch_cov_c: cover property (@(posedge core_clk_in) $fell(latched_r));
endmodule
`default_nettype wire

/* File: bench/meas_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Measuring core: frequency reads zero only at zero speed
module meas_core_model
  import preset_cmp_pkg::*;
(
  input  wire logic              clk_in,  // System clock
  input  wire logic [VAL_W-1:0]  rate_in, // Speed to report
  input  wire logic              fwd_in,  // Forward rotation
  output preset_cmp_pkg::speed_in_t spd_out // To comparator
);
  assign spd_out = {rate_in, rate_in == '0, fwd_in};
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import preset_cmp_pkg::*;
  logic             core_clk_in, rst_n_in, tick_in, start_p, clr_p, fwd;
  logic             switch_out, delay_busy_out;
  logic [VAL_W-1:0] rate;
  sw_cfg_t          cfg;
  speed_in_t        spd;
  int               bad_count, total_checks, cycles, i;
  int               md[11] = '{0, 0, 0, 1, 1, 4, 4, 5, 5, 7, 7};
  int               sp[11] = '{150, -150, 99, 100, -120, -150, 100, -150,
                               101, 5, -5};
  logic             ex[11] = '{1, 1, 0, 1, 0, 0, 1, 1, 0, 1, 0};
  meas_core_model u_meas_core_model (.clk_in(core_clk_in), .rate_in(rate),
    .fwd_in(fwd), .spd_out(spd));
  speed_preset_switch_compare u_speed_preset_switch_compare (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg),
    .spd_in(spd), .tick_in(tick_in), .meas_start_in(start_p),
    .latch_clr_in(clr_p), .switch_out(switch_out),
    .delay_busy_out(delay_busy_out));
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  task automatic step(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Apply mode and speed, let two edges pass, then compare
  task automatic put(input int m, input int s, input logic f, input logic e);
    cfg.mode = sw_mode_t'(m[2:0]);
    rate = s[VAL_W-1:0];
    fwd = f;
    step(2);
    chk({23'h0, switch_out}, {23'h0, e});
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    rst_n_in = 1'b0;
    tick_in = 1'b1;
    start_p = 1'b0;
    clr_p = 1'b0;
    fwd = 1'b0;
    rate = 24'h000000;
    cfg = '{MODE_ABS_GE, 1'b0, 24'h000064, 24'h00000A, 24'h000003,
            24'h000004};
    step(2);
    rst_n_in = 1'b1;
    for (i = 0; i < 11; i++) put(md[i], sp[i], sp[i] > 0, ex[i]);
    put(2, 50, 1'b1, 1'b1);
    put(2, 95, 1'b1, 1'b1);
    put(2, 110, 1'b1, 1'b0);
    put(2, 95, 1'b1, 1'b0);
    put(2, -90, 1'b0, 1'b1);
    put(6, -200, 1'b0, 1'b1);
    put(6, 110, 1'b1, 1'b0);
    put(3, 0, 1'b0, 1'b0);
    step(6);
    chk({23'h0, switch_out}, 24'h000001);
    put(1, 300, 1'b1, 1'b0);
    start_p = 1'b1;
    rate = 24'h000032;
    step(1);
    start_p = 1'b0;
    chk({23'h0, switch_out}, 24'h000000);
    step(1);
    chk({23'h0, delay_busy_out}, 24'h000001);
    chk({23'h0, switch_out}, 24'h000000);
    step(3);
    chk({22'h0, delay_busy_out, switch_out}, 24'h000002);
    step(1);
    chk({22'h0, delay_busy_out, switch_out}, 24'h000001);
    cfg.latch_en = 1'b1;
    put(0, 150, 1'b1, 1'b1);
    put(0, 20, 1'b1, 1'b1);
    clr_p = 1'b1;
    step(1);
    clr_p = 1'b0;
    step(1);
    chk({23'h0, switch_out}, 24'h000000);
    tick_in = 1'b0;
    put(3, 0, 1'b0, 1'b0);
    step(6);
    chk({23'h0, switch_out}, 24'h000000);
    tick_in = 1'b1;
    step(3);
    chk({23'h0, switch_out}, 24'h000000);
    step(1);
    chk({23'h0, switch_out}, 24'h000001);
    complete_run;
  end
endmodule
`default_nettype wire
